// ### tmr2_pkg.sv
// Constants for the 16-bit timer with capture and auto-reload.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
package tmr2_pkg;
  // Register indexes; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_MASK = 8'hC0;
  localparam logic [7:0] IDX_CTRL = 8'hC8;
  localparam logic [7:0] IDX_RLD_LO = 8'hCA;
  localparam logic [7:0] IDX_RLD_HI = 8'hCB;
  localparam logic [7:0] IDX_CNT_LO = 8'hCC;
  localparam logic [7:0] IDX_CNT_HI = 8'hCD;
  localparam logic [7:0] IDX_CLK_GATE = 8'hD8;
  // Control register bit positions.
  localparam int BIT_OVF_FLAG = 7;
  localparam int BIT_TRIG_FLAG = 6;
  localparam int BIT_RX_BAUD = 5;
  localparam int BIT_TX_BAUD = 4;
  localparam int BIT_TRIG_EN = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_TC_SEL = 1;
  localparam int BIT_CAP_SEL = 0;
  // Clock gating register bit position.
  localparam int BIT_IDLE_STOP = 4;
  // Reset values and count constants.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
endpackage

// ### tmr2_reg_if.sv
// Register access carrier between the bus slave and the timer core.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface tmr2_reg_if;
  logic wr_stb;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output wr_stb, output idx, output wdata, input rdata);
  modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface

// ### tmr2_fall_det.sv
// Falling edge finder for a pin that is synchronous to the clock.
// Assumes the pin is already synchronous to i_clk.
`timescale 1ns/1ps
module tmr2_fall_det (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  output logic o_fall
);
  logic now_reg;
  logic prev_reg;

  // Two successive samples; a high followed by a low is one fall.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      now_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      now_reg <= i_pin;
      prev_reg <= now_reg;
    end
  end

  assign o_fall = prev_reg & ~now_reg;

  fall_once_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_fall |=> !o_fall)
    else $error("trigger fall seen on two cycles in a row");
endmodule

// ### tmr2_wb_slave.sv
// Classic Wishbone slave that turns bus cycles into byte register accesses.
// Assumes a single-cycle classic master that holds its request until ack.
`timescale 1ns/1ps
module tmr2_wb_slave (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  tmr2_reg_if.bus reg_port
);
  logic ack_reg;
  logic [31:0] dat_reg;
  logic req;

  assign req = i_wb_cyc & i_wb_stb;
  assign reg_port.idx = i_wb_adr[9:2];
  assign reg_port.wdata = i_wb_dat[7:0];
  // The write lands on the edge where the master sees ack.
  assign reg_port.wr_stb = req & i_wb_we & i_wb_sel[0] & ack_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Unmapped reads return zero; the bits above the byte read as zero.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dat_reg <= 32'h0000_0000;
    end else if (req & ~ack_reg) begin
      dat_reg <= {24'h00_0000, reg_port.rdata};
    end
  end

  assign o_wb_ack = ack_reg;
  assign o_wb_dat = dat_reg;

  sequence ack_pulse_s;
    ack_reg ##1 !ack_reg;
  endsequence

  ack_one_cycle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    req && !ack_reg |=> ack_pulse_s)
    else $error("bus ack was not a single cycle pulse after a request");
endmodule

// ### tmr2_top.sv
// Timer core: 16-bit count with auto-reload, trigger capture, flags and interrupt.
// Assumes all inputs are synchronous to i_clk and a classic Wishbone master.
`timescale 1ns/1ps
module tmr2_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  input wire logic i_trigger_pin,
  input wire logic i_idle,
  output logic o_rx_baud_tick,
  output logic o_tx_baud_tick,
  output logic o_irq
);
  tmr2_reg_if reg_bus ();

  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] reload_reg;
  logic [15:0] reload_next;
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] mask_reg;
  logic idle_stop_reg;
  logic presc_reg;
  logic irq_reg;
  logic rx_tick_reg;
  logic tx_tick_reg;

  logic trig_fall;
  logic run;
  logic tc_sel;
  logic cap_sel;
  logic trig_en;
  logic rx_sel;
  logic tx_sel;
  logic baud_sel;
  logic reload_mode;
  logic gated;
  logic step;
  logic ovf;
  logic trig_act;
  logic trig_reload;
  logic trig_capture;
  logic wr_ctrl;
  logic wr_mask;
  logic wr_clk_gate;
  logic wr_rld_lo;
  logic wr_rld_hi;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic cnt_wr;
  logic rld_wr;
  logic [7:0] rdata;

  tmr2_wb_slave u_slave (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat),
    .o_wb_ack(o_wb_ack),
    .o_wb_dat(o_wb_dat),
    .reg_port(reg_bus.bus)
  );

  tmr2_fall_det u_fall (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_pin(i_trigger_pin),
    .o_fall(trig_fall)
  );

  // Write decode.
  assign wr_ctrl = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_CTRL);
  assign wr_mask = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_MASK);
  assign wr_clk_gate = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_CLK_GATE);
  assign wr_rld_lo = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_RLD_LO);
  assign wr_rld_hi = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_RLD_HI);
  assign wr_cnt_lo = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_CNT_LO);
  assign wr_cnt_hi = reg_bus.wr_stb & (reg_bus.idx == tmr2_pkg::IDX_CNT_HI);
  assign cnt_wr = wr_cnt_lo | wr_cnt_hi;
  assign rld_wr = wr_rld_lo | wr_rld_hi;

  // Control fields.
  assign run = ctrl_reg[tmr2_pkg::BIT_RUN];
  assign tc_sel = ctrl_reg[tmr2_pkg::BIT_TC_SEL];
  assign cap_sel = ctrl_reg[tmr2_pkg::BIT_CAP_SEL];
  assign trig_en = ctrl_reg[tmr2_pkg::BIT_TRIG_EN];
  assign rx_sel = ctrl_reg[tmr2_pkg::BIT_RX_BAUD];
  assign tx_sel = ctrl_reg[tmr2_pkg::BIT_TX_BAUD];
  assign baud_sel = rx_sel | tx_sel;
  assign reload_mode = ~cap_sel | baud_sel;

  // Timer frozen in idle when the peripheral clock stop is set.
  assign gated = idle_stop_reg & i_idle;

  // Both timer and counter selections step at half the system clock.
  assign step = run & ~gated & presc_reg;
  assign ovf = step & (count_reg == tmr2_pkg::CNT_ALL_ONES);

  assign trig_act = trig_fall & trig_en & ~gated;
  assign trig_reload = trig_act & reload_mode;
  assign trig_capture = trig_act & ~reload_mode;

  // Divide-by-two phase; holds while stopped or gated.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      presc_reg <= 1'b0;
    end else if (run & ~gated) begin
      presc_reg <= ~presc_reg;
    end
  end

  // Next count: a software byte write wins over hardware for that byte.
  always_comb begin
    count_next = count_reg;
    if (trig_reload) begin
      count_next = reload_reg;
    end else if (ovf) begin
      if (reload_mode) begin
        count_next = reload_reg;
      end else begin
        count_next = tmr2_pkg::RST_WORD;
      end
    end else if (step) begin
      count_next = count_reg + tmr2_pkg::CNT_ONE;
    end
    if (wr_cnt_lo) begin
      count_next[7:0] = reg_bus.wdata;
    end
    if (wr_cnt_hi) begin
      count_next[15:8] = reg_bus.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg <= tmr2_pkg::RST_WORD;
    end else begin
      count_reg <= count_next;
    end
  end

  // Next reload/capture value: a capture wins over a software write.
  always_comb begin
    reload_next = reload_reg;
    if (wr_rld_lo) begin
      reload_next[7:0] = reg_bus.wdata;
    end
    if (wr_rld_hi) begin
      reload_next[15:8] = reg_bus.wdata;
    end
    if (trig_capture) begin
      reload_next = count_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      reload_reg <= tmr2_pkg::RST_WORD;
    end else begin
      reload_reg <= reload_next;
    end
  end

  // Control register: flags clear on a written one, a same-cycle set wins.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[5:0] = reg_bus.wdata[5:0];
      ctrl_next[tmr2_pkg::BIT_OVF_FLAG] = ctrl_reg[tmr2_pkg::BIT_OVF_FLAG]
        & ~reg_bus.wdata[tmr2_pkg::BIT_OVF_FLAG];
      ctrl_next[tmr2_pkg::BIT_TRIG_FLAG] = ctrl_reg[tmr2_pkg::BIT_TRIG_FLAG]
        & ~reg_bus.wdata[tmr2_pkg::BIT_TRIG_FLAG];
    end
    if (ovf & ~baud_sel) begin
      ctrl_next[tmr2_pkg::BIT_OVF_FLAG] = 1'b1;
    end
    if (trig_act) begin
      ctrl_next[tmr2_pkg::BIT_TRIG_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_reg <= tmr2_pkg::RST_BYTE;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mask_reg <= tmr2_pkg::RST_BYTE;
    end else if (wr_mask) begin
      mask_reg <= reg_bus.wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      idle_stop_reg <= 1'b0;
    end else if (wr_clk_gate) begin
      idle_stop_reg <= reg_bus.wdata[tmr2_pkg::BIT_IDLE_STOP];
    end
  end

  // Overflow doubles as the serial baud tick for whichever direction selects it.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rx_tick_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
    end else begin
      rx_tick_reg <= ovf & rx_sel;
      tx_tick_reg <= ovf & tx_sel;
    end
  end

  // Level interrupt from the unmasked flags, one cycle behind the flags.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ctrl_reg[7:6] & mask_reg[7:6]);
    end
  end

  // Read mux; unmapped indexes read as zero.
  always_comb begin
    case (reg_bus.idx)
      tmr2_pkg::IDX_CTRL: rdata = ctrl_reg;
      tmr2_pkg::IDX_MASK: rdata = {mask_reg[7:6], 6'b00_0000};
      tmr2_pkg::IDX_RLD_LO: rdata = reload_reg[7:0];
      tmr2_pkg::IDX_RLD_HI: rdata = reload_reg[15:8];
      tmr2_pkg::IDX_CNT_LO: rdata = count_reg[7:0];
      tmr2_pkg::IDX_CNT_HI: rdata = count_reg[15:8];
      tmr2_pkg::IDX_CLK_GATE: rdata = {3'b000, idle_stop_reg, 4'h0};
      default: rdata = tmr2_pkg::RST_BYTE;
    endcase
  end

  assign reg_bus.rdata = rdata;
  assign o_rx_baud_tick = rx_tick_reg;
  assign o_tx_baud_tick = tx_tick_reg;
  assign o_irq = irq_reg;

  sequence top_step_s;
    step && (count_reg == tmr2_pkg::CNT_ALL_ONES) && !cnt_wr && !trig_act;
  endsequence

  sequence plain_step_s;
    step && (count_reg != tmr2_pkg::CNT_ALL_ONES) && !cnt_wr && !trig_act;
  endsequence

  hold_stopped_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !run && !cnt_wr && !trig_act |=> $stable(count_reg))
    else $error("count moved while the timer was stopped");

  step_value_a: assert property (@(posedge i_clk) disable iff (i_rst)
    plain_step_s |=> count_reg == $past(count_reg) + tmr2_pkg::CNT_ONE)
    else $error("count did not advance by one on a step");

  step_spacing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    step |=> !step)
    else $error("count stepped on two cycles in a row");

  counter_rate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    tc_sel && run && !gated ##1 tc_sel && run && !gated |-> step || $past(step))
    else $error("counter mode missed its half-rate step");

  reload_ovf_a: assert property (@(posedge i_clk) disable iff (i_rst)
    top_step_s ##0 reload_mode |=> count_reg == $past(reload_reg))
    else $error("overflow in reload mode did not load the reload value");

  trig_reload_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trig_reload && !cnt_wr |=> count_reg == $past(reload_reg))
    else $error("trigger fall in reload mode did not reload the count");

  capture_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trig_capture |=> reload_reg == $past(count_reg))
    else $error("trigger fall in capture mode did not capture the count");

  baud_force_a: assert property (@(posedge i_clk) disable iff (i_rst)
    top_step_s ##0 baud_sel && cap_sel |=> count_reg == $past(reload_reg))
    else $error("baud clock use did not force a reload on overflow");

  idle_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gated && !cnt_wr && !trig_act |=> $stable(count_reg))
    else $error("count moved while idle clock stop was active");

  ovf_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ovf && !baud_sel |=> ctrl_reg[tmr2_pkg::BIT_OVF_FLAG])
    else $error("overflow did not set the overflow flag");

  baud_no_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    baud_sel && !ctrl_reg[tmr2_pkg::BIT_OVF_FLAG] && !wr_ctrl
      |=> !ctrl_reg[tmr2_pkg::BIT_OVF_FLAG])
    else $error("overflow flag set while a baud clock select was high");

  trig_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    trig_act |=> ctrl_reg[tmr2_pkg::BIT_TRIG_FLAG])
    else $error("trigger action did not set the trigger flag");

  baud_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ovf |=> (o_tx_baud_tick == $past(tx_sel)) && (o_rx_baud_tick == $past(rx_sel)))
    else $error("baud tick did not follow the overflow");

  wrap_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    top_step_s ##0 !reload_mode |=> count_reg == tmr2_pkg::RST_WORD)
    else $error("count did not wrap to zero without a reload");

  irq_level_a: assert property (@(posedge i_clk) disable iff (i_rst)
    |(ctrl_reg[7:6] & mask_reg[7:6]) |=> o_irq)
    else $error("unmasked flag did not raise the interrupt");

  ovf_flag_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_reg[tmr2_pkg::BIT_OVF_FLAG] && !(ovf && !baud_sel)
      |=> !ctrl_reg[tmr2_pkg::BIT_OVF_FLAG])
    else $error("overflow flag set without a counted overflow");

  trig_flag_cause_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !ctrl_reg[tmr2_pkg::BIT_TRIG_FLAG] && !trig_act
      |=> !ctrl_reg[tmr2_pkg::BIT_TRIG_FLAG])
    else $error("trigger flag set without a trigger action");

  cnt_byte_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_cnt_lo |=> count_reg[7:0] == $past(reg_bus.wdata))
    else $error("count low byte write did not land");

  rld_byte_wr_a: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_rld_hi && !trig_capture |=> reload_reg[15:8] == $past(reg_bus.wdata))
    else $error("reload high byte write did not land");

  idle_capture_a: assert property (@(posedge i_clk) disable iff (i_rst)
    gated && !rld_wr |=> $stable(reload_reg))
    else $error("reload value changed by hardware while idle clock stop was active");

  tick_only_ovf_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !ovf |=> !o_rx_baud_tick && !o_tx_baud_tick)
    else $error("baud tick without an overflow");

  fall_found_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(i_trigger_pin) |=> trig_fall)
    else $error("trigger pin fall was not detected");
endmodule

// ### tmr2_trig_model.sv
// Model of the outside device that pulls the trigger pin low.
// Assumes requests come from the bench synchronous to i_clk.
`timescale 1ns/1ps
module tmr2_trig_model (
  input wire logic i_clk,
  input wire logic i_fire,
  input wire logic [7:0] i_low_len,
  output logic o_pin
);
  logic [7:0] low_cnt_reg = 8'h00;
  // The pin rests high and each request gives one clean low pulse of the asked length.
  always @(posedge i_clk) begin
    if (i_fire) begin
      low_cnt_reg <= i_low_len;
    end else if (low_cnt_reg != 8'h00) begin
      low_cnt_reg <= low_cnt_reg - 8'h01;
    end
  end
  assign o_pin = (low_cnt_reg == 8'h00);
endmodule

// ### tb_top.sv
// Self-checking bench for the timer with capture and auto-reload.
// Assumes the design acks each classic Wishbone request once, one cycle after taking it.
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] a_cnt = tmr2_pkg::IDX_CNT_LO;
  localparam logic [7:0] a_rld = tmr2_pkg::IDX_RLD_LO;
  localparam logic [7:0] a_ctl = tmr2_pkg::IDX_CTRL;
  localparam logic [7:0] a_msk = tmr2_pkg::IDX_MASK;
  localparam logic [7:0] a_clk = tmr2_pkg::IDX_CLK_GATE;
  localparam logic [7:0] b_run = 8'h01 << tmr2_pkg::BIT_RUN;
  localparam logic [7:0] b_cap = 8'h01 << tmr2_pkg::BIT_CAP_SEL;
  localparam logic [7:0] b_trg = 8'h01 << tmr2_pkg::BIT_TRIG_EN;
  localparam logic [7:0] b_ovf = 8'h01 << tmr2_pkg::BIT_OVF_FLAG;
  localparam logic [7:0] b_tfl = 8'h01 << tmr2_pkg::BIT_TRIG_FLAG;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic idle = 1'b0;
  logic fire = 1'b0;
  logic [7:0] low_len = 8'h0C;
  logic ack, pin, rx_tick, tx_tick, irq;
  logic [31:0] rdat;
  logic [7:0] reset_idx [8] = '{8'hC0, 8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hD8, 8'h10};
  int bad_count = 0;
  int cmp_count = 0;
  int rx_seen = 0;
  int tx_seen = 0;

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  tmr2_top u_tmr2_top (.i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_trigger_pin(pin), .i_idle(idle), .o_rx_baud_tick(rx_tick),
    .o_tx_baud_tick(tx_tick), .o_irq(irq));
  tmr2_trig_model u_tmr2_trig_model (.i_clk(i_clk), .i_fire(fire), .i_low_len(low_len),
    .o_pin(pin));

  always @(posedge i_clk) begin
    if (rx_tick === 1'b1) rx_seen <= rx_seen + 1;
    if (tx_tick === 1'b1) tx_seen <= tx_seen + 1;
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high at a rising edge.
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                    input logic s0, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= {3'b000, s0};
    adr <= {idx, 2'b00};
    wdat <= {24'h00_0000, wd};
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("BAD bus ack expected 1 seen timeout");
      complete_run();
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    wb(1'b1, idx, wd, 1'b1, d);
  endtask

  task automatic wr16(input logic [7:0] idx, input logic [15:0] v);
    wr(idx, v[7:0]);
    wr(idx + 8'h01, v[15:8]);
  endtask

  task automatic expect8(input string what, input logic [7:0] idx, input logic [15:0] exp);
    logic [7:0] d;
    wb(1'b0, idx, 8'h00, 1'b1, d);
    check(what, {8'h00, d}, exp);
  endtask

  task automatic expect16(input string what, input logic [7:0] idx, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    wb(1'b0, idx, 8'h00, 1'b1, lo);
    wb(1'b0, idx + 8'h01, 8'h00, 1'b1, hi);
    check(what, {hi, lo}, exp);
  endtask

  // Twenty cycles of run time, an even span, so ten steps whatever the prescaler phase.
  task automatic run_win(input logic [7:0] ctl, input logic [15:0] start);
    wr16(a_cnt, start);
    wr(a_ctl, ctl | b_run);
    repeat (17) @(posedge i_clk);
    wr(a_ctl, ctl);
  endtask

  task automatic fire_trig(input logic [7:0] len);
    low_len <= len;
    fire <= 1'b1;
    @(posedge i_clk);
    fire <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask

  task automatic wait_pin;
    int n;
    n = 0;
    while (pin !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      $display("BAD trigger pin expected 1 seen 0");
      complete_run();
    end
    repeat (4) @(posedge i_clk);
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge i_clk);
    check("irq", {15'h0000, irq}, {15'h0000, exp});
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] b;
    int rx0;
    int tx0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (reset_idx[i]) expect8("reset value", reset_idx[i], 16'h0000);
    wr16(a_rld, 16'h5AA5);
    wr16(a_cnt, 16'h3CC3);
    expect16("reload bytes", a_rld, 16'h5AA5);
    expect16("count bytes", a_cnt, 16'h3CC3);
    wb(1'b1, a_rld, 8'h11, 1'b0, d);
    expect8("unselected write", a_rld, 16'h00A5);
    wr(8'h10, 8'hFF);
    expect8("unmapped", 8'h10, 16'h0000);
    run_win(8'h00, 16'h0000);
    expect16("timer steps", a_cnt, 16'h000A);
    repeat (10) @(posedge i_clk);
    expect16("stopped hold", a_cnt, 16'h000A);
    run_win(8'h01 << tmr2_pkg::BIT_TC_SEL, 16'h0000);
    expect16("counter steps", a_cnt, 16'h000A);
    wr16(a_rld, 16'h1234);
    run_win(8'h00, 16'hFFFE);
    expect16("overflow reload", a_cnt, 16'h123C);
    expect8("overflow flag", a_ctl, {8'h00, b_ovf});
    irq_is(1'b0);
    wr(a_msk, b_ovf);
    irq_is(1'b1);
    wr(a_ctl, b_ovf);
    irq_is(1'b0);
    expect8("flag cleared", a_ctl, 16'h0000);
    run_win(b_cap, 16'hFFFE);
    expect16("wrap to zero", a_cnt, 16'h0008);
    expect16("pair kept", a_rld, 16'h1234);
    wr(a_ctl, b_ovf);
    for (int i = 0; i < 2; i++) begin
      b = 8'h01 << ((i == 0) ? tmr2_pkg::BIT_RX_BAUD : tmr2_pkg::BIT_TX_BAUD);
      rx0 = rx_seen;
      tx0 = tx_seen;
      wr16(a_rld, 16'h0100);
      run_win(b | b_cap, 16'hFFFE);
      expect16("forced reload", a_cnt, 16'h0108);
      expect8("no flag when baud", a_ctl, {8'h00, b | b_cap});
      check("rx ticks", 16'(rx_seen - rx0), (i == 0) ? 16'h0001 : 16'h0000);
      check("tx ticks", 16'(tx_seen - tx0), (i == 1) ? 16'h0001 : 16'h0000);
      wr(a_ctl, 8'h00);
    end
    wr16(a_cnt, 16'h1111);
    wr(a_ctl, b_trg);
    fire_trig(8'h0C);
    wait_pin();
    expect16("trigger reload", a_cnt, 16'h0100);
    expect8("trigger flag", a_ctl, {8'h00, b_tfl | b_trg});
    wr(a_msk, b_ovf | b_tfl);
    irq_is(1'b1);
    wr(a_ctl, b_tfl | b_trg);
    irq_is(1'b0);
    wr16(a_cnt, 16'h5A5A);
    wr(a_ctl, b_trg | b_cap);
    fire_trig(8'h3C);
    expect16("capture", a_rld, 16'h5A5A);
    wr16(a_cnt, 16'h0001);
    expect16("one act per edge", a_rld, 16'h5A5A);
    wait_pin();
    expect8("capture flag", a_ctl, {8'h00, b_tfl | b_trg | b_cap});
    wr(a_ctl, b_tfl | b_cap);
    wr16(a_cnt, 16'h2222);
    fire_trig(8'h0C);
    wait_pin();
    expect16("disabled trigger", a_rld, 16'h5A5A);
    expect8("no trigger flag", a_ctl, {8'h00, b_cap});
    wr(a_clk, 8'h01 << tmr2_pkg::BIT_IDLE_STOP);
    expect8("clock stop bit", a_clk, 16'h0010);
    idle <= 1'b1;
    run_win(8'h00, 16'h0000);
    expect16("gated hold", a_cnt, 16'h0000);
    wr(a_ctl, b_trg | b_cap);
    fire_trig(8'h0C);
    wait_pin();
    expect16("gated trigger", a_rld, 16'h5A5A);
    idle <= 1'b0;
    run_win(8'h00, 16'h0000);
    expect16("ungated steps", a_cnt, 16'h000A);
    complete_run();
  end
endmodule
